// ---- rtl/psimd_pkg.sv ----
/*
 * Shared definitions for the packed-integer vector datapath: operation
 * codes, the issue and write-back carriers, and the fixed latency.
 * Assumes a single core clock domain.
 */
package psimd_pkg;

    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int PSIMD_VEC_W = 128;
    localparam int PSIMD_LATENCY = 2; // issue edge to result valid, in cycles
    localparam logic [7:0] PSIMD_RST_BYTE = 8'h00;

    // rounding constant added at the lsb of the 18-bit product slice
    localparam logic [17:0] PSIMD_RND_ONE = 18'h00001;

    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        PSIMD_OP_MULHRS,     // rounded_high_multiply
        PSIMD_OP_SHUF,       // byte_shuffle
        PSIMD_OP_NEG_B,      // conditional_negate byte
        PSIMD_OP_NEG_W,
        PSIMD_OP_NEG_D,
        PSIMD_OP_ALIGN,      // align_right
        PSIMD_OP_MULLO_D,    // low_dword_multiply
        PSIMD_OP_MULWIDE_D,  // widening_dword_multiply
        PSIMD_OP_BLEND_W,    // word_blend
        PSIMD_OP_BLENDV_B,   // variable_byte_blend
        PSIMD_OP_MIN_UW,
        PSIMD_OP_MIN_UD,
        PSIMD_OP_MIN_SB,
        PSIMD_OP_MIN_SD,
        PSIMD_OP_MAX_UW,
        PSIMD_OP_MAX_UD,
        PSIMD_OP_MAX_SB,
        PSIMD_OP_MAX_SD,
        PSIMD_OP_INS_B,
        PSIMD_OP_INS_D,
        PSIMD_OP_INS_Q,
        PSIMD_OP_EXT_B,
        PSIMD_OP_EXT_W,
        PSIMD_OP_EXT_D,
        PSIMD_OP_EXT_Q,
        PSIMD_OP_SP_INS,     // single_precision_insert
        PSIMD_OP_SP_EXT,     // single_precision_extract
        PSIMD_OP_SX_BW,
        PSIMD_OP_SX_BD,
        PSIMD_OP_SX_BQ,
        PSIMD_OP_SX_WD,
        PSIMD_OP_SX_WQ,
        PSIMD_OP_SX_DQ,
        PSIMD_OP_ZX_BW,
        PSIMD_OP_ZX_BD,
        PSIMD_OP_ZX_BQ,
        PSIMD_OP_ZX_WD,
        PSIMD_OP_ZX_WQ,
        PSIMD_OP_ZX_DQ
    } psimd_op_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        psimd_op_t op;
        logic align_half;          // align_right on a 64-bit operand pair
        logic [7:0] imm;
        logic [127:0] dst;         // destination operand (first)
        logic [127:0] src;         // source operand (second)
        logic [127:0] mask;        // implicit blend mask register
        logic [63:0] scalar;       // scalar register or memory value
    } psimd_issue_t;

    typedef struct packed {
        logic valid;
        logic to_scalar;           // result goes to scalar register or memory
        logic [127:0] vec;
        logic [63:0] scalar;
    } psimd_result_t;

endpackage

// ---- rtl/psimd_datapath.sv ----
/*
 * Packed-integer vector datapath: multiplies, shuffle, negate, align,
 * blends, min/max, element insert/extract and width conversions.
 * Assumes issue logic on core_clk presents one request per cycle at most
 * and the write-back side always accepts the result.
 * Extracts answer on the scalar side with the vector cleared; every
 * other code, legal or not, answers on the vector side.
 */
module psimd_datapath
    import psimd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire psimd_issue_t issue,
    output psimd_result_t result
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        psimd_issue_t stage1;      // captured request
        psimd_result_t stage2;     // computed result
    } psimd_state_t;

    psimd_state_t state;
    psimd_state_t next_state;

    // ------------------------------------------------------------
    // compute, all from the captured request
    // ------------------------------------------------------------
    function automatic logic [127:0] psimd_compute(input psimd_issue_t q);
        logic [127:0] r;
        logic [255:0] cat;
        logic signed [31:0] p32;
        logic [17:0] p18;
        logic signed [63:0] p64;
        logic [3:0] ix;
        logic [7:0] cb;
        logic [31:0] ins_elem;
        // scratch values are cleared first so every path assigns them
        r = '0;
        cat = '0;
        p32 = '0;
        p18 = '0;
        p64 = '0;
        ix = '0;
        cb = '0;
        ins_elem = '0;
        unique case (q.op)
            // 16x16 signed lanes, rounded and scaled back to 16 bits
            PSIMD_OP_MULHRS:
            begin
                for (int i = 0; i < 8; i++)
                begin
                    p32 = $signed(q.dst[i*16 +: 16]) * $signed(q.src[i*16 +: 16]);
                    // bits 31:14 are the 18 msbs, the +1 rounds at their lsb
                    p18 = p32[31:14] + PSIMD_RND_ONE;
                    r[i*16 +: 16] = p18[16:1];
                end
            end

            // control bytes come from src
            PSIMD_OP_SHUF:
            begin
                // control is only read; the src field is never written back
                for (int i = 0; i < 16; i++)
                begin
                    cb = q.src[i*8 +: 8];
                    ix = cb[3:0];
                    r[i*8 +: 8] = cb[7] ? PSIMD_RST_BYTE : q.dst[ix*8 +: 8];
                end
            end

            // sign of the src element decides; zero src keeps dst
            PSIMD_OP_NEG_B:
                for (int i = 0; i < 16; i++)
                    r[i*8 +: 8] = q.src[i*8+7] ? 8'(-q.dst[i*8 +: 8]) : q.dst[i*8 +: 8];

            // word lanes
            PSIMD_OP_NEG_W:
                for (int i = 0; i < 8; i++)
                    r[i*16 +: 16] = q.src[i*16+15] ? 16'(-q.dst[i*16 +: 16]) : q.dst[i*16 +: 16];

            // dword lanes
            PSIMD_OP_NEG_D:
                for (int i = 0; i < 4; i++)
                    r[i*32 +: 32] = q.src[i*32+31] ? 32'(-q.dst[i*32 +: 32]) : q.dst[i*32 +: 32];

            // byte offset from imm over the joined operands;
            // half mode uses the low qword of each operand
            PSIMD_OP_ALIGN:
            begin
                // offsets past the double-width value shift in zeros
                if (q.align_half)
                    cat = {128'h0, q.dst[63:0], q.src[63:0]};
                else
                    cat = {q.dst, q.src};
                cat = cat >> {q.imm, 3'b000};
                r = q.align_half ? {64'h0, cat[63:0]} : cat[127:0];
            end

            // low half of each product; sign does not matter there
            PSIMD_OP_MULLO_D:
                for (int i = 0; i < 4; i++)
                begin
                    p64 = $signed(q.dst[i*32 +: 32]) * $signed(q.src[i*32 +: 32]);
                    r[i*32 +: 32] = p64[31:0];
                end

            // full products of the even dword lanes;
            // the odd lanes are ignored
            PSIMD_OP_MULWIDE_D:
                for (int i = 0; i < 2; i++)
                begin
                    // even dword lanes feed the two products
                    p64 = $signed(q.dst[i*64 +: 32]) * $signed(q.src[i*64 +: 32]);
                    r[i*64 +: 64] = p64;
                end

            // imm bit i picks src word i
            PSIMD_OP_BLEND_W:
                for (int i = 0; i < 8; i++)
                    r[i*16 +: 16] = q.imm[i] ? q.src[i*16 +: 16] : q.dst[i*16 +: 16];

            // bit 7 of each mask byte picks the src byte
            PSIMD_OP_BLENDV_B:
                for (int i = 0; i < 16; i++)
                    r[i*8 +: 8] = q.mask[i*8+7] ? q.src[i*8 +: 8] : q.dst[i*8 +: 8];

            // min and max share one compare per lane;
            // the op code flips which operand wins
            PSIMD_OP_MIN_UW, PSIMD_OP_MAX_UW:
                for (int i = 0; i < 8; i++)
                    r[i*16 +: 16] = ((q.dst[i*16 +: 16] < q.src[i*16 +: 16]) == (q.op == PSIMD_OP_MIN_UW))
                        ? q.dst[i*16 +: 16] : q.src[i*16 +: 16];

            // unsigned dword lanes
            PSIMD_OP_MIN_UD, PSIMD_OP_MAX_UD:
                for (int i = 0; i < 4; i++)
                    r[i*32 +: 32] = ((q.dst[i*32 +: 32] < q.src[i*32 +: 32]) == (q.op == PSIMD_OP_MIN_UD))
                        ? q.dst[i*32 +: 32] : q.src[i*32 +: 32];

            // signed byte lanes;
            // equal lanes give the same value either way
            PSIMD_OP_MIN_SB, PSIMD_OP_MAX_SB:
                for (int i = 0; i < 16; i++)
                    r[i*8 +: 8] = (($signed(q.dst[i*8 +: 8]) < $signed(q.src[i*8 +: 8]))
                        == (q.op == PSIMD_OP_MIN_SB)) ? q.dst[i*8 +: 8] : q.src[i*8 +: 8];

            // signed dword lanes
            PSIMD_OP_MIN_SD, PSIMD_OP_MAX_SD:
                for (int i = 0; i < 4; i++)
                    r[i*32 +: 32] = (($signed(q.dst[i*32 +: 32]) < $signed(q.src[i*32 +: 32]))
                        == (q.op == PSIMD_OP_MIN_SD)) ? q.dst[i*32 +: 32] : q.src[i*32 +: 32];

            // insert keeps dst and overwrites one element;
            // the index field cannot point outside the vector
            PSIMD_OP_INS_B:
            begin
                r = q.dst;
                r[q.imm[3:0]*8 +: 8] = q.scalar[7:0];
            end

            // dword insert from the low scalar half
            PSIMD_OP_INS_D:
            begin
                r = q.dst;
                r[q.imm[1:0]*32 +: 32] = q.scalar[31:0];
            end

            // qword insert, imm bit 0 picks the half
            PSIMD_OP_INS_Q:
            begin
                r = q.dst;
                r[q.imm[0]*64 +: 64] = q.scalar;
            end

            // element move with zero mask, raw bits only
            PSIMD_OP_SP_INS:
            begin
                // imm[7:6] source lane, imm[5:4] target lane, imm[3:0] zero mask;
                // align_half set takes the element from the scalar (memory) value
                ins_elem = q.align_half ? q.scalar[31:0] : q.src[q.imm[7:6]*32 +: 32];
                r = q.dst;
                r[q.imm[5:4]*32 +: 32] = ins_elem;
                for (int i = 0; i < 4; i++)
                    if (q.imm[i])
                        r[i*32 +: 32] = '0;
            end

            // sign-extending widenings read the low src elements;
            // the upper src bytes are ignored
            PSIMD_OP_SX_BW:
                for (int i = 0; i < 8; i++)
                    r[i*16 +: 16] = {{8{q.src[i*8+7]}}, q.src[i*8 +: 8]};

            // bytes to dwords
            PSIMD_OP_SX_BD:
                for (int i = 0; i < 4; i++)
                    r[i*32 +: 32] = {{24{q.src[i*8+7]}}, q.src[i*8 +: 8]};

            // bytes to qwords
            PSIMD_OP_SX_BQ:
                for (int i = 0; i < 2; i++)
                    r[i*64 +: 64] = {{56{q.src[i*8+7]}}, q.src[i*8 +: 8]};

            // words to dwords
            PSIMD_OP_SX_WD:
                for (int i = 0; i < 4; i++)
                    r[i*32 +: 32] = {{16{q.src[i*16+15]}}, q.src[i*16 +: 16]};

            // words to qwords
            PSIMD_OP_SX_WQ:
                for (int i = 0; i < 2; i++)
                    r[i*64 +: 64] = {{48{q.src[i*16+15]}}, q.src[i*16 +: 16]};

            // dwords to qwords
            PSIMD_OP_SX_DQ:
                for (int i = 0; i < 2; i++)
                    r[i*64 +: 64] = {{32{q.src[i*32+31]}}, q.src[i*32 +: 32]};

            // zero-extending widenings, same element pairing
            // as the sign-extending ones
            PSIMD_OP_ZX_BW:
                for (int i = 0; i < 8; i++)
                    r[i*16 +: 16] = {8'h00, q.src[i*8 +: 8]};

            // bytes to dwords
            PSIMD_OP_ZX_BD:
                for (int i = 0; i < 4; i++)
                    r[i*32 +: 32] = {24'h000000, q.src[i*8 +: 8]};

            // bytes to qwords
            PSIMD_OP_ZX_BQ:
                for (int i = 0; i < 2; i++)
                    r[i*64 +: 64] = {56'h0, q.src[i*8 +: 8]};

            // words to dwords
            PSIMD_OP_ZX_WD:
                for (int i = 0; i < 4; i++)
                    r[i*32 +: 32] = {16'h0000, q.src[i*16 +: 16]};

            // words to qwords
            PSIMD_OP_ZX_WQ:
                for (int i = 0; i < 2; i++)
                    r[i*64 +: 64] = {48'h0, q.src[i*16 +: 16]};

            // dwords to qwords
            PSIMD_OP_ZX_DQ:
                for (int i = 0; i < 2; i++)
                    r[i*64 +: 64] = {32'h00000000, q.src[i*32 +: 32]};

            // extracts answer on the scalar side instead
            default:
                r = '0; // extracts and any illegal code leave the vector at zero
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // scalar result of the extract operations
    // ------------------------------------------------------------
    function automatic logic [63:0] psimd_extract(input psimd_issue_t q);
        logic [63:0] s;
        s = '0;
        unique case (q.op)
            // index in the low imm bits, upper imm bits ignored
            PSIMD_OP_EXT_B: s = {56'h0, q.dst[q.imm[3:0]*8 +: 8]};
            PSIMD_OP_EXT_W: s = {48'h0, q.dst[q.imm[2:0]*16 +: 16]};
            PSIMD_OP_EXT_D: s = {32'h00000000, q.dst[q.imm[1:0]*32 +: 32]};
            PSIMD_OP_EXT_Q: s = q.dst[q.imm[0]*64 +: 64];
            // element handed over as raw bits
            PSIMD_OP_SP_EXT: s = {32'h00000000, q.dst[q.imm[1:0]*32 +: 32]};
            default: s = '0;
        endcase
        return s;
    endfunction

    // extracts steer write-back to the scalar register side
    function automatic logic psimd_is_scalar(input psimd_op_t op);
        return op inside {PSIMD_OP_EXT_B, PSIMD_OP_EXT_W, PSIMD_OP_EXT_D, PSIMD_OP_EXT_Q, PSIMD_OP_SP_EXT};
    endfunction

    // ------------------------------------------------------------
    // next state: capture, then compute; two-stage fixed latency
    // ------------------------------------------------------------
    // the split keeps the wide multipliers off the issue path at the cost
    // of one extra cycle; operands are 128-bit except the scalar value of the inserts and the align_half form of align_right
    always_comb
    begin
        next_state = state;
        next_state.stage1 = issue;
        next_state.stage2.valid = state.stage1.valid;
        next_state.stage2.to_scalar = psimd_is_scalar(state.stage1.op);
        next_state.stage2.vec = psimd_compute(state.stage1);
        next_state.stage2.scalar = psimd_extract(state.stage1);
        if (!state.stage1.valid)
        begin
            next_state.stage2.vec = '0; // idle cycles show a quiet bus
            next_state.stage2.scalar = '0;
            next_state.stage2.to_scalar = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // async clear drops any request in flight; both stages go idle
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state <= '0;
        else
            state <= next_state;
    end

    // the port is the second stage flop itself, nothing after it
    assign result = state.stage2;

endmodule // psimd_datapath

// ---- test/psimd_datapath_assertions.sv ----
/*
 * Checker for the vector datapath ports.
 * Assumes one core_clk domain and an active-high asynchronous rst.
 */
module psimd_datapath_assertions
    import psimd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire psimd_issue_t issue,
    input wire psimd_result_t result
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_lat;
        issue.valid |-> ##2 result.valid;
    endproperty
    a_lat: assert property (p_lat) else $error("result valid missing");
    property p_pulse;
        result.valid |-> $past(issue.valid, 2);
    endproperty
    a_pulse: assert property (p_pulse) else $error("result valid without request");
    property p_idle;
        !result.valid |-> result.vec == '0 && result.scalar == '0;
    endproperty
    a_idle: assert property (p_idle) else $error("idle result not zero");
    property p_zero;
        issue.valid && issue.op == PSIMD_OP_SHUF && (issue.src & {16{8'h80}}) == {16{8'h80}} |-> ##2 result.vec == '0;
    endproperty
    a_zero: assert property (p_zero) else $error("shuffle byte not zeroed");
    property p_keep;
        issue.valid && issue.op == PSIMD_OP_BLEND_W && issue.imm == 8'h00 |-> ##2 result.vec == $past(issue.dst, 2);
    endproperty
    a_keep: assert property (p_keep) else $error("word blend changed dst");
    property p_vmask;
        issue.valid && issue.op == PSIMD_OP_BLENDV_B && issue.mask == '0 |-> ##2 result.vec == $past(issue.dst, 2);
    endproperty
    a_vmask: assert property (p_vmask) else $error("byte blend changed dst");
    property p_ext;
        issue.valid && issue.op inside {PSIMD_OP_EXT_B, PSIMD_OP_EXT_Q, PSIMD_OP_SP_EXT} |-> ##2 result.to_scalar;
    endproperty
    a_ext: assert property (p_ext) else $error("extract not scalar");
    property p_neg;
        issue.valid && issue.op == PSIMD_OP_NEG_D && issue.src == '0 |-> ##2 result.vec == $past(issue.dst, 2);
    endproperty
    a_neg: assert property (p_neg) else $error("negate on zero source");
    property p_zx;
        issue.valid && issue.op == PSIMD_OP_ZX_BQ |-> ##2 result.vec[63:8] == '0 && result.vec[127:72] == '0;
    endproperty
    a_zx: assert property (p_zx) else $error("zero extend upper bits set");
    property p_sx;
        issue.valid && issue.op == PSIMD_OP_SX_DQ |-> ##2 result.vec[63:32] == {32{$past(issue.src[31], 2)}};
    endproperty
    a_sx: assert property (p_sx) else $error("sign extend wrong");
endmodule // psimd_datapath_assertions

bind psimd_datapath psimd_datapath_assertions i_psimd_datapath_assertions (.core_clk(core_clk), .rst(rst),
    .issue(issue), .result(result));

// ---- test/psimd_issue_model.sv ----
/*
 * Issue-side model: presents one request per call.
 * Assumes the caller waits for the result before the next call.
 */
module psimd_issue_model
    import psimd_pkg::*;
(
    input wire logic core_clk,
    output psimd_issue_t issue
);
    timeunit 1ns;
    timeprecision 1ps;
    initial issue = '0;
    // fields scramble once released so stale operands cannot pass
    task automatic send(input psimd_issue_t req);
        @(posedge core_clk);
        #1 issue = req;
        @(posedge core_clk);
        #1 issue = {1'b0, ~req[$bits(psimd_issue_t)-2:0]};
    endtask
endmodule // psimd_issue_model

// ---- test/psimd_datapath_tb.sv ----
/*
 * Self-checking bench for the vector datapath.
 * Assumes the checker is bound in and the issue model drives requests.
 */
module psimd_datapath_tb;
    import psimd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk;
    logic rst;
    psimd_issue_t issue;
    psimd_result_t result;
    int fails;
    int samples_checked;
    logic [127:0] ev;
    logic [127:0] d = 128'h8000_7FFF_C000_4000_FEDC_1234_0001_FFFF;
    logic [127:0] s = 128'h8000_8000_0380_F10F_7FFF_0102_8E05_0C0B;
    logic [127:0] mk = 128'h80FF_007F_8001_FE00_0080_7F80_00FF_1280;
    logic [63:0] sc = 64'hA5C3_0F1E_2D3C_4B5A;

    psimd_datapath i_psimd_datapath (.core_clk(core_clk), .rst(rst), .issue(issue), .result(result));
    psimd_issue_model i_psimd_issue_model (.core_clk(core_clk), .issue(issue));

    function automatic logic [63:0] m(int w);
        return (w == 64) ? {64{1'b1}} : (64'h1 << w) - 64'h1;
    endfunction
    function automatic logic [63:0] el(logic [127:0] v, int w, int i);
        return 64'(v >> (i * w)) & m(w);
    endfunction
    // replace lane i of width w
    function automatic logic [127:0] put(logic [127:0] v, int w, int i, logic [63:0] x);
        return (v & ~(128'(m(w)) << (i * w))) | (128'(x & m(w)) << (i * w));
    endfunction
    task automatic results();
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(logic [127:0] got, logic [127:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one request; the answer must come on the first edge after it is taken
    task automatic go(psimd_op_t op, logic [7:0] imm, logic half, logic [127:0] xv, logic [63:0] xs, logic xt);
        int n;
        i_psimd_issue_model.send(psimd_issue_t'({1'b1, op, half, imm, d, s, mk, sc}));
        for (n = 0; n < 4 && result.valid !== 1'b1; n++)
        begin
            @(posedge core_clk);
            #1;
        end
        cmp(128'(n), 128'h1);
        if (result.valid !== 1'b1)
            results();
        cmp(result.vec, xv);
        cmp(128'({result.to_scalar, result.scalar}), 128'({xt, xs}));
    endtask
    task automatic t_mul();
        logic signed [31:0] p;
        logic [17:0] t;
        logic signed [63:0] q;
        for (int i = 0; i < 8; i++)
        begin
            p = $signed(16'(el(d, 16, i))) * $signed(16'(el(s, 16, i)));
            t = p[31:14] + 18'h00001;
            ev = put(ev, 16, i, 64'(t[16:1]));
        end
        go(PSIMD_OP_MULHRS, 8'h00, 1'b0, ev, '0, 1'b0);
        for (int i = 0; i < 4; i++)
            ev = put(ev, 32, i, el(d, 32, i) * el(s, 32, i));
        go(PSIMD_OP_MULLO_D, 8'h00, 1'b0, ev, '0, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            q = $signed(32'(el(d, 32, 2 * i))) * $signed(32'(el(s, 32, 2 * i)));
            ev = put(ev, 64, i, q);
        end
        go(PSIMD_OP_MULWIDE_D, 8'h00, 1'b0, ev, '0, 1'b0);
    endtask
    task automatic t_perm();
        logic [63:0] c;
        for (int i = 0; i < 16; i++)
        begin
            c = el(s, 8, i);
            ev = put(ev, 8, i, c[7] ? 64'h0 : el(d, 8, int'(c[3:0])));
        end
        go(PSIMD_OP_SHUF, 8'h00, 1'b0, ev, '0, 1'b0);
        go(PSIMD_OP_ALIGN, 8'h05, 1'b0, 128'({d, s} >> 40), '0, 1'b0);
        go(PSIMD_OP_ALIGN, 8'h03, 1'b1, {64'h0, 64'({d[63:0], s[63:0]} >> 24)}, '0, 1'b0);
        go(PSIMD_OP_ALIGN, 8'h20, 1'b0, '0, '0, 1'b0);
        for (int i = 0; i < 8; i++)
            ev = put(ev, 16, i, (8'hA5 >> i) & 8'h01 ? el(s, 16, i) : el(d, 16, i));
        go(PSIMD_OP_BLEND_W, 8'hA5, 1'b0, ev, '0, 1'b0);
        for (int i = 0; i < 16; i++)
            ev = put(ev, 8, i, mk[8 * i + 7] ? el(s, 8, i) : el(d, 8, i));
        go(PSIMD_OP_BLENDV_B, 8'h00, 1'b0, ev, '0, 1'b0);
    endtask
    task automatic t_sign();
        int w;
        logic [63:0] x;
        logic [63:0] y;
        logic [63:0] sg;
        for (int k = 0; k < 3; k++)
        begin
            w = 8 << k;
            for (int i = 0; i < 128 / w; i++)
            begin
                x = el(s, w, i);
                y = el(d, w, i);
                ev = put(ev, w, i, x[w-1] ? -y : y);
            end
            go(psimd_op_t'(PSIMD_OP_NEG_B + k), 8'h00, 1'b0, ev, '0, 1'b0);
        end
        // flipping the sign bit lets signed lanes use an unsigned compare
        for (int k = 0; k < 8; k++)
        begin
            w = (k % 4 == 0) ? 16 : (k % 4 == 2) ? 8 : 32;
            sg = (k % 4 >= 2) ? 64'h1 << (w - 1) : 64'h0;
            for (int i = 0; i < 128 / w; i++)
            begin
                x = el(s, w, i) ^ sg;
                y = el(d, w, i) ^ sg;
                ev = put(ev, w, i, ((k >= 4) ? x > y : x < y) ? el(s, w, i) : el(d, w, i));
            end
            go(psimd_op_t'(PSIMD_OP_MIN_UW + k), 8'h00, 1'b0, ev, '0, 1'b0);
        end
    endtask
    task automatic t_move();
        int w;
        for (int k = 0; k < 3; k++)
        begin
            w = (k == 0) ? 8 : (k == 1) ? 32 : 64;
            go(psimd_op_t'(PSIMD_OP_INS_B + k), 8'h01, 1'b0, put(d, w, 1, sc), '0, 1'b0);
        end
        for (int k = 0; k < 4; k++)
        begin
            w = 8 << k;
            go(psimd_op_t'(PSIMD_OP_EXT_B + k), 8'(128 / w - 1), 1'b0, '0, el(d, w, 128 / w - 1), 1'b1);
        end
        go(PSIMD_OP_SP_INS, 8'hD4, 1'b0, put(put(d, 32, 1, el(s, 32, 3)), 32, 2, '0), '0, 1'b0);
        go(PSIMD_OP_SP_INS, 8'h31, 1'b1, put(put(d, 32, 3, sc), 32, 0, '0), '0, 1'b0);
        go(PSIMD_OP_SP_EXT, 8'h02, 1'b0, '0, el(d, 32, 2), 1'b1);
    endtask
    task automatic t_conv();
        int sw;
        int dw;
        logic [63:0] x;
        for (int k = 0; k < 12; k++)
        begin
            sw = (k % 6 < 3) ? 8 : (k % 6 < 5) ? 16 : 32;
            dw = (k % 6 == 0) ? 16 : (k % 6 == 1 || k % 6 == 3) ? 32 : 64;
            for (int i = 0; i < 128 / dw; i++)
            begin
                x = el(s, sw, i);
                if (k < 6 && x[sw-1])
                    x = x | ~m(sw);
                ev = put(ev, dw, i, x);
            end
            go(psimd_op_t'(PSIMD_OP_SX_BW + k), 8'h00, 1'b0, ev, '0, 1'b0);
        end
    endtask
    // boundary operands: all control bytes zeroing, zero source, empty selects
    task automatic t_edges();
        s = {16{8'h80}};
        go(PSIMD_OP_SHUF, 8'h00, 1'b0, '0, '0, 1'b0);
        go(PSIMD_OP_BLEND_W, 8'h00, 1'b0, d, '0, 1'b0);
        s = '0;
        go(PSIMD_OP_NEG_D, 8'h00, 1'b0, d, '0, 1'b0);
        mk = '0;
        go(PSIMD_OP_BLENDV_B, 8'h00, 1'b0, d, '0, 1'b0);
    endtask
    // reset in flight drops the request and keeps the result quiet
    task automatic t_reset();
        i_psimd_issue_model.send(psimd_issue_t'({1'b1, PSIMD_OP_SX_BW, 1'b0, 8'h00, d, s, mk, sc}));
        rst = 1'b1;
        repeat (3)
        begin
            @(posedge core_clk);
            #1;
            cmp(128'({result.valid, result.to_scalar, result.scalar}), '0);
            cmp(result.vec, '0);
        end
        rst = 1'b0;
        go(PSIMD_OP_EXT_Q, 8'h00, 1'b0, '0, d[63:0], 1'b1);
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        fails = 0;
        samples_checked = 0;
        rst = 1'b1;
        repeat (20) @(posedge core_clk);
        #1 rst = 1'b0;
        t_mul();
        t_perm();
        t_sign();
        t_move();
        t_conv();
        t_edges();
        t_reset();
        results();
    end
endmodule // psimd_datapath_tb
